/* rtl/pdma_pkg.sv */
// shared constants and types for the peripheral dma engine
package pdma_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int PER_N = 4;
    localparam int PER_MAX = 12;
    localparam int CH_N = 2 * PER_N;
    localparam int CHW = 3;
    localparam int ASB_N = 1;
    localparam int AW = 32;
    localparam int CW = 16;
    localparam int DW = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = CHW + DW;
    localparam int MEM_N = 64;
    localparam int MEM_AW = 6;
    localparam int IDX_LO = 2;

    // ------------------------------------------------------------
    // bus field values
    // ------------------------------------------------------------
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] PROT_DATA = 2'h1;
    localparam logic [AW-1:0] PTR_STEP = 32'h0000_0004;
    localparam logic [AW-1:0] PTR_RST = 32'h0000_0000;
    localparam logic [CW-1:0] CNT_ONE = 16'h0001;
    localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
    localparam logic [DW-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [AW-1:0] BRIDGE_MASK = 32'hFFFF_0000;
    localparam logic [AW-1:0] BRIDGE_BASE = 32'hFFFF_0000;

    // ------------------------------------------------------------
    // channel register select
    // ------------------------------------------------------------
    localparam logic [1:0] CFG_PTR = 2'h0;
    localparam logic [1:0] CFG_CNT = 2'h1;
    localparam logic [1:0] CFG_NPTR = 2'h2;
    localparam logic [1:0] CFG_NCNT = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_REQ = 2'h1,
        ST_PERI = 2'h2,
        ST_BUS = 2'h3
    } pdma_state_t;

    typedef struct packed {
        pdma_state_t st;
        logic [CHW-1:0] ch;
        logic [CH_N-1:0] pend;
        logic [CH_N-1:0][AW-1:0] ptr;
        logic [CH_N-1:0][AW-1:0] nptr;
        logic [CH_N-1:0][CW-1:0] cnt;
        logic [CH_N-1:0][CW-1:0] ncnt;
        logic [DW-1:0] data;
    } pdma_dev_t;

    typedef struct packed {
        logic [ASB_N-1:0] gnt;
        logic waited;
        logic bsel;
        logic [DW-1:0] rdata;
        logic [CH_N-1:0] zero_prev;
        logic [PER_N-1:0] irq;
        logic [MEM_N-1:0][DW-1:0] mem;
    } pdma_sys_t;

endpackage

/* rtl/pdma_if.sv */
// link between the dma engine and its system bus and peripherals
`timescale 1ns/1ns
`default_nettype none
interface pdma_if;
    logic [pdma_pkg::ASB_N-1:0] agnt;
    logic [pdma_pkg::ASB_N-1:0] bwait;
    logic bridge_sel;
    logic [pdma_pkg::ASB_N-1:0] areq;
    logic oe_master_address;
    logic [pdma_pkg::AW-1:0] master_add;
    logic bus_lock;
    logic [1:0] bus_prot;
    logic [1:0] bus_size;
    logic bus_write;
    logic [pdma_pkg::DW-1:0] bus_wdata;
    logic [pdma_pkg::DW-1:0] bus_rdata;
    logic [pdma_pkg::PER_N-1:0] tx_trig;
    logic [pdma_pkg::PER_N-1:0] rx_trig;
    logic [pdma_pkg::CH_N-1:0] cnt_zero;

    modport dev (
        input agnt, bwait, bridge_sel, bus_rdata, tx_trig, rx_trig,
        output areq, oe_master_address, master_add, bus_lock, bus_prot,
        output bus_size, bus_write, bus_wdata, cnt_zero
    );
    modport sys (
        output agnt, bwait, bridge_sel, bus_rdata, tx_trig, rx_trig,
        input areq, oe_master_address, master_add, bus_lock, bus_prot,
        input bus_size, bus_write, bus_wdata, cnt_zero
    );
endinterface
`default_nettype wire

/* rtl/pdma_fifo.sv */
// parameterised word fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module pdma_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16,
    parameter int PW = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW:0] wp;
        logic [PW:0] rp;
    } pdma_fifo_t;

    pdma_fifo_t r_reg;
    pdma_fifo_t r_next;
    logic full;
    logic empty;

    // pointers carry one extra bit so full and empty differ
    assign empty = r_reg.wp == r_reg.rp;
    assign full = (r_reg.wp[PW] != r_reg.rp[PW]) &&
                  (r_reg.wp[PW-1:0] == r_reg.rp[PW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = r_reg.mem[r_reg.rp[PW-1:0]];

    always_comb begin
        r_next = r_reg;
        if (in_valid && !full) begin
            r_next.mem[r_reg.wp[PW-1:0]] = in_data;
            r_next.wp = r_reg.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            r_next.rp = r_reg.rp + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r_reg.wp <= '0;
            r_reg.rp <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule
`default_nettype wire

/* rtl/pdma_dev.sv */
// dma engine end: channel pairs, scheduler and system bus master
`timescale 1ns/1ns
`default_nettype none
module pdma_dev (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // system bus side
    pdma_if.dev bus,
    // channel register load from the owning peripheral
    input wire logic cfg_we,
    input wire logic [pdma_pkg::CHW-1:0] cfg_ch,
    input wire logic [1:0] cfg_sel,
    input wire logic [pdma_pkg::AW-1:0] cfg_wdata,
    // channel state readback
    input wire logic [pdma_pkg::CHW-1:0] stat_ch,
    output logic [pdma_pkg::AW-1:0] stat_ptr,
    output logic [pdma_pkg::CW-1:0] stat_cnt,
    // receive data fetch from the peripheral
    output logic rx_rd,
    output logic [pdma_pkg::CHW-1:0] rx_rd_ch,
    input wire logic [pdma_pkg::DW-1:0] rx_data,
    output logic bridge_own,
    // transmit data toward the peripherals
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [pdma_pkg::CHW-1:0] tx_ch,
    output logic [pdma_pkg::DW-1:0] tx_data
);
    pdma_pkg::pdma_dev_t r_reg;
    pdma_pkg::pdma_dev_t r_next;
    logic [pdma_pkg::CH_N-1:0] set;
    logic [pdma_pkg::CH_N-1:0] live;
    logic [pdma_pkg::CH_N-1:0] elig;
    logic [pdma_pkg::CHW-1:0] pick;
    logic any;
    logic cur_rx;
    logic done;
    logic push;
    logic push_ready;
    logic [pdma_pkg::CW-1:0] cnt_dec;
    logic [pdma_pkg::FIFO_W-1:0] pop_word;

    // ------------------------------------------------------------
    // transmit buffer
    // ------------------------------------------------------------
    pdma_fifo #(
        .W(pdma_pkg::FIFO_W),
        .DEPTH(pdma_pkg::FIFO_DEPTH),
        .PW(4)
    ) u_txq (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(push_ready),
        .in_data({r_reg.ch, bus.bus_rdata}),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(pop_word)
    );
    assign tx_ch = pop_word[pdma_pkg::FIFO_W-1:pdma_pkg::DW];
    assign tx_data = pop_word[pdma_pkg::DW-1:0];

    // ------------------------------------------------------------
    // channel pairing and eligibility
    // ------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < pdma_pkg::PER_N; p++) begin
            set[2*p] = bus.rx_trig[p];
            set[2*p+1] = bus.tx_trig[p];
        end
        for (int c = 0; c < pdma_pkg::CH_N; c++) begin
            live[c] = r_reg.cnt[c] != pdma_pkg::CNT_ZERO;
            // tx channels wait while the buffer cannot take a word
            elig[c] = r_reg.pend[c] && live[c] && (!c[0] || push_ready);
        end
    end

    // lowest channel wins; fixed priority keeps the scheduler small
    always_comb begin
        pick = '0;
        any = 1'b0;
        for (int c = pdma_pkg::CH_N - 1; c >= 0; c--) begin
            if (elig[c]) begin
                pick = c[pdma_pkg::CHW-1:0];
                any = 1'b1;
            end
        end
    end

    assign cur_rx = !r_reg.ch[0];
    // completion only once wait is low
    assign done = (r_reg.st == pdma_pkg::ST_BUS) && bus.agnt[0] &&
                  !bus.bwait[0];
    assign push = done && !cur_rx;
    assign cnt_dec = r_reg.cnt[r_reg.ch] - pdma_pkg::CNT_ONE;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        // triggers ignored while count is zero
        r_next.pend = r_reg.pend | (set & live);
        if (cfg_we) begin
            case (cfg_sel)
                pdma_pkg::CFG_PTR: r_next.ptr[cfg_ch] = cfg_wdata;
                pdma_pkg::CFG_CNT:
                    r_next.cnt[cfg_ch] = cfg_wdata[pdma_pkg::CW-1:0];
                pdma_pkg::CFG_NPTR: r_next.nptr[cfg_ch] = cfg_wdata;
                pdma_pkg::CFG_NCNT:
                    r_next.ncnt[cfg_ch] = cfg_wdata[pdma_pkg::CW-1:0];
                default: r_next.ptr[cfg_ch] = r_reg.ptr[cfg_ch];
            endcase
        end
        case (r_reg.st)
            pdma_pkg::ST_IDLE: begin
                if (any) begin
                    r_next.ch = pick;
                    r_next.st = pdma_pkg::ST_REQ;
                end
            end
            pdma_pkg::ST_REQ: begin
                if (bus.agnt[0]) begin
                    // tx straight to bus, rx via fetch
                    r_next.st = cur_rx ? pdma_pkg::ST_PERI
                                       : pdma_pkg::ST_BUS;
                end
            end
            pdma_pkg::ST_PERI: begin
                // take the bridge only when bus not using it
                if (!bus.bridge_sel) begin
                    r_next.data = rx_data;
                    r_next.st = pdma_pkg::ST_BUS;
                end
            end
            pdma_pkg::ST_BUS: begin
                if (done) begin
                    r_next.st = pdma_pkg::ST_IDLE;
                    // advance, or reload from next at zero
                    if (cnt_dec == pdma_pkg::CNT_ZERO) begin
                        r_next.ptr[r_reg.ch] = r_reg.nptr[r_reg.ch];
                        r_next.cnt[r_reg.ch] = r_reg.ncnt[r_reg.ch];
                        r_next.ncnt[r_reg.ch] = pdma_pkg::CNT_ZERO;
                    end else begin
                        r_next.ptr[r_reg.ch] =
                            r_reg.ptr[r_reg.ch] + pdma_pkg::PTR_STEP;
                        r_next.cnt[r_reg.ch] = cnt_dec;
                    end
                    // a trigger in this same cycle survives the clear
                    r_next.pend[r_reg.ch] = set[r_reg.ch];
                end
            end
            default: r_next.st = pdma_pkg::ST_IDLE;
        endcase
        // a pointer or count load on the active channel wins over the advance
        if (cfg_we && cfg_ch == r_reg.ch && done) begin
            case (cfg_sel)
                pdma_pkg::CFG_PTR: r_next.ptr[cfg_ch] = cfg_wdata;
                pdma_pkg::CFG_CNT:
                    r_next.cnt[cfg_ch] = cfg_wdata[pdma_pkg::CW-1:0];
                default: r_next.ch = r_reg.ch;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r_reg.st <= pdma_pkg::ST_IDLE;
            r_reg.ch <= '0;
            r_reg.pend <= '0;
            r_reg.ptr <= {pdma_pkg::CH_N{pdma_pkg::PTR_RST}};
            r_reg.nptr <= {pdma_pkg::CH_N{pdma_pkg::PTR_RST}};
            r_reg.cnt <= {pdma_pkg::CH_N{pdma_pkg::CNT_ZERO}};
            r_reg.ncnt <= {pdma_pkg::CH_N{pdma_pkg::CNT_ZERO}};
            r_reg.data <= pdma_pkg::DATA_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // bus outputs
    // ------------------------------------------------------------
    always_comb begin
        // request from selection until transfer ends
        bus.areq = '0;
        bus.areq[0] = r_reg.st != pdma_pkg::ST_IDLE;
        // address enable only while granted in address phase
        bus.oe_master_address = (r_reg.st == pdma_pkg::ST_BUS) &&
                                bus.agnt[0];
        // word address from the current pointer
        bus.master_add = r_reg.ptr[r_reg.ch];
        // rx fetch and store must not be split
        bus.bus_lock = (r_reg.st == pdma_pkg::ST_PERI) ||
                       ((r_reg.st == pdma_pkg::ST_BUS) && cur_rx);
        bus.bus_prot = pdma_pkg::PROT_DATA;
        bus.bus_size = pdma_pkg::SIZE_WORD;
        // write when moving peripheral data into memory
        bus.bus_write = (r_reg.st == pdma_pkg::ST_BUS) && cur_rx;
        bus.bus_wdata = r_reg.data;
        for (int c = 0; c < pdma_pkg::CH_N; c++) begin
            bus.cnt_zero[c] = !live[c];
        end
    end

    // only wait is honoured; there is no retract path
    assign rx_rd = (r_reg.st == pdma_pkg::ST_PERI) && !bus.bridge_sel;
    assign rx_rd_ch = r_reg.ch;
    assign bridge_own = r_reg.st == pdma_pkg::ST_PERI;
    assign stat_ptr = r_reg.ptr[stat_ch];
    assign stat_cnt = r_reg.cnt[stat_ch];
endmodule
`default_nettype wire

/* rtl/pdma_sys.sv */
// far end: bus arbiter, memory with one wait cycle, decoder, peripherals
`timescale 1ns/1ns
`default_nettype none
module pdma_sys (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // link to the dma engine
    pdma_if.sys bus,
    // peripheral triggers
    input wire logic [pdma_pkg::PER_N-1:0] tx_trig_in,
    input wire logic [pdma_pkg::PER_N-1:0] rx_trig_in,
    // other system bus traffic, for the decoder
    input wire logic sys_valid,
    input wire logic [pdma_pkg::AW-1:0] sys_addr,
    // memory preload
    input wire logic mem_we,
    input wire logic [pdma_pkg::MEM_AW-1:0] mem_idx,
    input wire logic [pdma_pkg::DW-1:0] mem_wdata,
    // end of transfer interrupts
    output logic [pdma_pkg::PER_N-1:0] eot_irq,
    input wire logic [pdma_pkg::PER_N-1:0] eot_ack
);
    pdma_pkg::pdma_sys_t r_reg;
    pdma_pkg::pdma_sys_t r_next;
    logic [pdma_pkg::MEM_AW-1:0] idx;
    logic [pdma_pkg::CH_N-1:0] rise;

    assign idx = bus.master_add[pdma_pkg::MEM_AW+pdma_pkg::IDX_LO-1:
                                pdma_pkg::IDX_LO];
    assign bus.tx_trig = tx_trig_in;
    assign bus.rx_trig = rx_trig_in;
    // grant bit 0 from the single arbiter
    assign bus.agnt = r_reg.gnt;
    // exactly one wait cycle per address phase
    assign bus.bwait = {pdma_pkg::ASB_N{bus.oe_master_address &&
                                        !r_reg.waited}};
    assign bus.bridge_sel = r_reg.bsel;
    assign bus.bus_rdata = r_reg.rdata;
    assign eot_irq = r_reg.irq;
    assign rise = bus.cnt_zero & ~r_reg.zero_prev;

    always_comb begin
        r_next = r_reg;
        r_next.gnt = bus.areq;
        // decoder flags accesses aimed at the bridge
        r_next.bsel = sys_valid &&
            ((sys_addr & pdma_pkg::BRIDGE_MASK) == pdma_pkg::BRIDGE_BASE);
        r_next.zero_prev = bus.cnt_zero;
        if (bus.oe_master_address && !r_reg.waited) begin
            r_next.waited = 1'b1;
            r_next.rdata = r_reg.mem[idx];
        end else if (bus.oe_master_address) begin
            r_next.waited = 1'b0;
            if (bus.bus_write) begin
                r_next.mem[idx] = bus.bus_wdata;
            end
        end else begin
            r_next.waited = 1'b0;
        end
        if (mem_we) begin
            r_next.mem[mem_idx] = mem_wdata;
        end
        for (int p = 0; p < pdma_pkg::PER_N; p++) begin
            // raise on either channel running dry; set wins
            r_next.irq[p] = (r_reg.irq[p] && !eot_ack[p]) ||
                            rise[2*p] || rise[2*p+1];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r_reg.gnt <= '0;
            r_reg.waited <= 1'b0;
            r_reg.bsel <= 1'b0;
            r_reg.rdata <= pdma_pkg::DATA_RST;
            r_reg.zero_prev <= '1;
            r_reg.irq <= '0;
            r_reg.mem <= r_next.mem;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule
`default_nettype wire

/* bench/pdma_asserts.sv */
// concurrent checks on the link between the dma engine and its system
`timescale 1ns/1ns
`default_nettype none
module pdma_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // arbiter side
    input wire logic [pdma_pkg::ASB_N-1:0] agnt,
    input wire logic [pdma_pkg::ASB_N-1:0] bwait,
    input wire logic bridge_sel,
    // engine side
    input wire logic [pdma_pkg::ASB_N-1:0] areq,
    input wire logic oe_master_address,
    input wire logic [pdma_pkg::AW-1:0] master_add,
    input wire logic bus_lock,
    input wire logic [1:0] bus_prot,
    input wire logic [1:0] bus_size,
    input wire logic bus_write,
    input wire logic [pdma_pkg::CH_N-1:0] cnt_zero
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_addr_phase;
        oe_master_address && bwait[0] ##1 oe_master_address && !bwait[0];
    endsequence
    sequence s_store;
        oe_master_address && bus_write && bus_lock;
    endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    // one wait then release
    a_one_wait_phase: assert property
        ($rose(oe_master_address) |-> s_addr_phase ##1 !oe_master_address)
        else $error("address phase not one wait plus one data cycle");
    a_rx_two_cycles: assert property
        (bus_lock && !oe_master_address && !bridge_sel |=> s_store)
        else $error("store did not follow fetch");
    a_oe_needs_gnt: assert property
        (oe_master_address |-> agnt[0])
        else $error("address enabled without grant");
    a_fields_valid: assert property
        (oe_master_address |-> bus_size == pdma_pkg::SIZE_WORD
            && bus_prot == pdma_pkg::PROT_DATA)
        else $error("size or protection wrong");
    a_hold_in_wait: assert property
        (oe_master_address && bwait[0] |=> $stable(master_add)
            && $stable(bus_write) && $stable(bus_lock))
        else $error("outputs moved during wait");
    a_lock_on_store: assert property
        (oe_master_address && bus_write |-> bus_lock)
        else $error("store without lock");
    // no request with all counts zero
    a_zero_no_req: assert property
        ($rose(areq[0]) |-> !(&cnt_zero))
        else $error("request with every count zero");
    a_req_gets_gnt: assert property
        ($rose(areq[0]) |=> agnt[0])
        else $error("request not granted next cycle");
    a_reset_idle: assert property
        ($fell(rst) |-> &cnt_zero && !areq[0] && !oe_master_address)
        else $error("engine not idle after reset");
endmodule
`default_nettype wire

/* bench/pdma_tb_top.sv */
// self-checking bench: dma engine facing its system model
`timescale 1ns/1ns
`default_nettype none
module pdma_tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_we = 1'b0;
    logic [2:0] cfg_ch = 3'h0;
    logic [1:0] cfg_sel = 2'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic [2:0] stat_ch = 3'h0;
    logic [31:0] stat_ptr, tx_data, rx_data = 32'h0, sys_addr = 32'h0;
    logic [15:0] stat_cnt;
    logic rx_rd, bridge_own, tx_valid, tx_ready = 1'b0, sys_valid = 1'b0;
    logic [2:0] rx_rd_ch, tx_ch;
    logic [3:0] tx_trig_in = 4'h0, rx_trig_in = 4'h0, eot_irq;
    logic [3:0] eot_ack = 4'h0;
    logic mem_we = 1'b0;
    logic [5:0] mem_idx = 6'h0;
    logic [31:0] mem_wdata = 32'h0;
    int n_errors = 0;
    int checked = 0;

    always #2 sys_clk = ~sys_clk;

    pdma_if bus_if ();
    pdma_dev pdma_dev_inst (.sys_clk(sys_clk), .rst(rst), .bus(bus_if),
        .cfg_we(cfg_we), .cfg_ch(cfg_ch), .cfg_sel(cfg_sel),
        .cfg_wdata(cfg_wdata), .stat_ch(stat_ch), .stat_ptr(stat_ptr),
        .stat_cnt(stat_cnt), .rx_rd(rx_rd), .rx_rd_ch(rx_rd_ch),
        .rx_data(rx_data), .bridge_own(bridge_own), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_ch(tx_ch), .tx_data(tx_data));
    pdma_sys pdma_sys_inst (.sys_clk(sys_clk), .rst(rst), .bus(bus_if),
        .tx_trig_in(tx_trig_in), .rx_trig_in(rx_trig_in),
        .sys_valid(sys_valid), .sys_addr(sys_addr), .mem_we(mem_we),
        .mem_idx(mem_idx), .mem_wdata(mem_wdata), .eot_irq(eot_irq),
        .eot_ack(eot_ack));
    pdma_asserts pdma_asserts_inst (.sys_clk(sys_clk), .rst(rst),
        .agnt(bus_if.agnt), .bwait(bus_if.bwait),
        .bridge_sel(bus_if.bridge_sel), .areq(bus_if.areq),
        .oe_master_address(bus_if.oe_master_address),
        .master_add(bus_if.master_add), .bus_lock(bus_if.bus_lock),
        .bus_prot(bus_if.bus_prot), .bus_size(bus_if.bus_size),
        .bus_write(bus_if.bus_write), .cnt_zero(bus_if.cnt_zero));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] mw(input int i);
        return 32'hC0DE_0000 | 32'(i);
    endfunction

    task automatic check(input string what, input logic [31:0] e,
            input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // four back-to-back writes: ptr, cnt, next ptr, next cnt
    task automatic load(input logic [2:0] ch, input logic [31:0] p, c,
            np, nc);
        logic [31:0] v[4];
        v = '{p, c, np, nc};
        cfg_we <= 1'b1;
        cfg_ch <= ch;
        for (int s = 0; s < 4; s++) begin
            cfg_sel <= s[1:0];
            cfg_wdata <= v[s];
            @(posedge sys_clk);
        end
        cfg_we <= 1'b0;
    endtask

    task automatic stat(input logic [2:0] ch, input logic [31:0] p,
            input logic [15:0] c);
        stat_ch <= ch;
        @(negedge sys_clk);
        check("stat_ptr", p, stat_ptr);
        check("stat_cnt", 32'(c), 32'(stat_cnt));
        @(posedge sys_clk);
    endtask

    // waits for a word, judges it, then takes it in one ready cycle
    task automatic pop(input logic [2:0] ch, input logic [31:0] d);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (tx_valid !== 1'b1 && n < 60) begin
            @(negedge sys_clk);
            n++;
        end
        check("tx_valid", 32'h1, 32'(tx_valid));
        check("tx_ch", 32'(ch), 32'(tx_ch));
        check("tx_data", d, tx_data);
        @(posedge sys_clk);
        tx_ready <= 1'b1;
        @(posedge sys_clk);
        tx_ready <= 1'b0;
    endtask

    task automatic trig_tx(input logic [3:0] m);
        tx_trig_in <= m;
        @(posedge sys_clk);
        tx_trig_in <= 4'h0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int c = 0; c < 8; c++) begin
            stat(3'(c), 32'h0, 16'h0);
        end
        check("cnt_zero", 32'hFF, 32'(bus_if.cnt_zero));
        check("tx_valid", 32'h0, 32'(tx_valid));
        $display("t_reset done");
    endtask

    task automatic t_config();
        load(3'h5, 32'hFFFF_FFFC, 32'hABCD_0003, 32'h0, 32'h0);
        stat(3'h5, 32'hFFFF_FFFC, 16'h0003);
        check("cnt_zero5", 32'h0, 32'(bus_if.cnt_zero[5]));
        load(3'h5, 32'h0, 32'h0, 32'h0, 32'h0);
        $display("t_config done");
    endtask

    task automatic t_tx();
        logic seen;
        load(3'h1, 32'h80, 32'h2, 32'hC0, 32'h1);
        trig_tx(4'h1);
        pop(3'h1, mw(32));
        stat(3'h1, 32'h84, 16'h1);
        trig_tx(4'h1);
        pop(3'h1, mw(33));
        stat(3'h1, 32'hC0, 16'h1);
        trig_tx(4'h1);
        pop(3'h1, mw(48));
        stat(3'h1, 32'hC0, 16'h0);
        check("eot_irq", 32'h1, 32'(eot_irq[0]));
        eot_ack <= 4'h1;
        @(posedge sys_clk);
        eot_ack <= 4'h0;
        trig_tx(4'h1);
        seen = 1'b0;
        repeat (12) begin
            @(negedge sys_clk);
            seen = seen | bus_if.areq[0] | tx_valid;
        end
        check("idle_req", 32'h0, 32'(seen));
        check("eot_clr", 32'h0, 32'(eot_irq[0]));
        @(posedge sys_clk);
        $display("t_tx done");
    endtask

    // fetch is held off while other traffic owns the bridge
    task automatic t_rx();
        int n;
        rx_data <= 32'h5A5A_1234;
        sys_valid <= 1'b1;
        sys_addr <= 32'hFFFF_0010;
        load(3'h0, 32'hF0, 32'h1, 32'h0, 32'h0);
        rx_trig_in <= 4'h1;
        @(posedge sys_clk);
        rx_trig_in <= 4'h0;
        repeat (6) @(posedge sys_clk);
        sys_valid <= 1'b0;
        n = 0;
        @(negedge sys_clk);
        while (rx_rd !== 1'b1 && n < 60) begin
            @(negedge sys_clk);
            n++;
        end
        check("rx_rd", 32'h1, 32'(rx_rd));
        check("rx_rd_ch", 32'h0, 32'(rx_rd_ch));
        check("bridge_sel", 32'h0, 32'(bus_if.bridge_sel));
        check("bridge_own", 32'h1, 32'(bridge_own));
        repeat (8) @(posedge sys_clk);
        stat(3'h0, 32'h0, 16'h0);
        load(3'h1, 32'hF0, 32'h1, 32'h0, 32'h0);
        trig_tx(4'h1);
        pop(3'h1, 32'h5A5A_1234);
        $display("t_rx done");
    endtask

    // fill until the full fifo refuses, then drain in order
    task automatic t_fifo();
        load(3'h3, 32'h0, 32'h11, 32'h0, 32'h0);
        tx_trig_in <= 4'h2;
        repeat (150) @(posedge sys_clk);
        tx_trig_in <= 4'h0;
        stat(3'h3, 32'h40, 16'h1);
        for (int k = 0; k < 17; k++) begin
            pop(3'h3, mw(k));
        end
        stat(3'h3, 32'h0, 16'h0);
        check("eot_irq1", 32'h1, 32'(eot_irq[1]));
        $display("t_fifo done");
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        mem_we <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            mem_idx <= 6'(i);
            mem_wdata <= mw(i);
            @(posedge sys_clk);
        end
        mem_we <= 1'b0;
        t_reset();
        t_config();
        t_tx();
        t_rx();
        t_fifo();
        wrap_up();
    end

    // the run needs well under 2000 cycles
    initial begin
        #80000;
        n_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
